/* File: design/rcd_ref_clock_divider.v */
// Reference clock output divider with AXI4-Lite register access
`timescale 1ns/1ps
`include "rcd_regs.vh"
module rcd_ref_clock_divider (
    // Clock and reset
    input  wire                      core_clk,
    input  wire                      rst_b,
    // AXI4-Lite write address and data
    input  wire [`RCD_ADDR_W-1:0]    s_axi_awaddr,
    input  wire                      s_axi_awvalid,
    output wire                      s_axi_awready,
    input  wire [31:0]               s_axi_wdata,
    input  wire [3:0]                s_axi_wstrb,
    input  wire                      s_axi_wvalid,
    output wire                      s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]                s_axi_bresp,
    output reg                       s_axi_bvalid,
    input  wire                      s_axi_bready,
    // AXI4-Lite read
    input  wire [`RCD_ADDR_W-1:0]    s_axi_araddr,
    input  wire                      s_axi_arvalid,
    output wire                      s_axi_arready,
    output reg  [31:0]               s_axi_rdata,
    output reg  [1:0]                s_axi_rresp,
    output reg                       s_axi_rvalid,
    input  wire                      s_axi_rready,
    // Clock sources 1 to 15, asynchronous levels
    input  wire [`RCD_SRC_N-1:0]     srcClkIn,
    // Power state
    input  wire                      sleepMode,
    input  wire [`RCD_SRC_N:0]       srcSleepEnabled,
    // Reference clock towards the output pin mapper
    output reg                       refclkOutputFunction,
    output reg                       refclkPinOut
);

// ------------------------------------------------------------
// Register state
// ------------------------------------------------------------
reg                       enableQ;
reg  [`RCD_SEL_W-1:0]     selQ;
reg                       sleepRunQ;
reg                       pinOeQ;
reg                       switchQ;
reg                       activeQ;
reg  [`RCD_DIV_W-1:0]     divQ;
reg  [`RCD_TRIM_W-1:0]    trimQ;

// ------------------------------------------------------------
// Bus channel state
// ------------------------------------------------------------
reg                       awHeldQ;
reg  [`RCD_ADDR_W-1:0]    awAddrQ;
reg                       wHeldQ;
reg  [31:0]               wDataQ;
reg  [3:0]                wStrbQ;

assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
assign s_axi_wready  = !wHeldQ && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire writeGo = awHeldQ && wHeldQ && !s_axi_bvalid;
wire readGo  = s_axi_arvalid && s_axi_arready;

function mapped;
    input [`RCD_ADDR_W-1:0] a;
    begin
        mapped = (a == `RCD_ADDR_CTRL_LO) || (a == `RCD_ADDR_CTRL_HI)
              || (a == `RCD_ADDR_TRIM);
    end
endfunction

// Merge byte lanes 0 and 1 into a 16-bit register image
function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
        merge16 = { strb[1] ? data[15:8] : old[15:8],
                    strb[0] ? data[7:0]  : old[7:0] };
    end
endfunction

// ------------------------------------------------------------
// Register images
// ------------------------------------------------------------
reg [15:0] ctrlLoImage;
reg [15:0] ctrlHiImage;
reg [15:0] trimImage;

always @* begin
    ctrlLoImage = 16'h0000;
    ctrlLoImage[`RCD_EN_BIT]  = enableQ;
    ctrlLoImage[`RCD_OE_BIT]  = pinOeQ;
    ctrlLoImage[`RCD_SLP_BIT] = sleepRunQ;
    ctrlLoImage[`RCD_SW_BIT]  = switchQ;
    ctrlLoImage[`RCD_ACT_BIT] = activeQ;
    ctrlLoImage[`RCD_SEL_HI:`RCD_SEL_LO] = selQ;
    ctrlHiImage = 16'h0000;
    ctrlHiImage[`RCD_DIV_HI:`RCD_DIV_LO] = divQ;
    trimImage = 16'h0000;
    trimImage[`RCD_TRIM_HI:`RCD_TRIM_LO] = trimQ;
end

wire [15:0] loNew   = merge16(ctrlLoImage, wDataQ, wStrbQ);
wire [15:0] hiNew   = merge16(ctrlHiImage, wDataQ, wStrbQ);
wire [15:0] trimNew = merge16(trimImage, wDataQ, wStrbQ);
wire wrLo   = writeGo && (awAddrQ == `RCD_ADDR_CTRL_LO);
wire wrHi   = writeGo && (awAddrQ == `RCD_ADDR_CTRL_HI);
wire wrTrim = writeGo && (awAddrQ == `RCD_ADDR_TRIM);
wire swSet  = wrLo && loNew[`RCD_SW_BIT];

// ------------------------------------------------------------
// Source synchronisers and tick selection
// ------------------------------------------------------------
reg  [`RCD_SRC_N-1:0] srcMetaQ;
reg  [`RCD_SRC_N-1:0] srcSyncQ;
reg  [`RCD_SRC_N-1:0] srcLastQ;

always @(posedge core_clk) begin
    if (!rst_b) begin
        srcMetaQ <= {`RCD_SRC_N{1'b0}};
        srcSyncQ <= {`RCD_SRC_N{1'b0}};
        srcLastQ <= {`RCD_SRC_N{1'b0}};
    end else begin
        srcMetaQ <= srcClkIn;
        srcSyncQ <= srcMetaQ;
        srcLastQ <= srcSyncQ;
    end
end

wire [`RCD_SRC_N:0] srcLevel = {srcSyncQ, 1'b0};
wire [`RCD_SRC_N:0] srcRise  = {srcSyncQ & ~srcLastQ, 1'b1};
// System clock source ticks every cycle and follows clock switches
wire srcTick  = srcRise[selQ];
wire srcHigh  = srcLevel[selQ];
wire srcAlive = !sleepMode
             || (sleepRunQ && srcSleepEnabled[selQ]);
wire running  = activeQ && srcAlive;

// ------------------------------------------------------------
// Divider core
// ------------------------------------------------------------
reg  [`RCD_DIV_W-1:0]  divActQ;
reg  [`RCD_TRIM_W-1:0] trimActQ;
reg  [`RCD_DIV_W:0]    cntQ;
reg  [`RCD_TRIM_W-1:0] accQ;
reg                    extraQ;
reg                    outQ;

wire [`RCD_DIV_W:0]    halfTerm = {1'b0, divActQ} + {{`RCD_DIV_W{1'b0}}, extraQ};
wire [`RCD_DIV_W:0]    cntNext  = cntQ + {{`RCD_DIV_W{1'b0}}, 1'b1};
wire [`RCD_TRIM_W:0]   accSum   = {1'b0, accQ} + {1'b0, trimActQ};
wire bypass   = (divActQ == `RCD_DIV_RST);
wire halfDone = srcTick && !bypass && (cntNext >= halfTerm);
// A half period boundary, or a stopped core, is safe for new values
wire boundary = !running || (srcTick && (bypass || halfDone));
wire applyNew = switchQ && boundary;

always @(posedge core_clk) begin
    if (!rst_b) begin
        divActQ  <= `RCD_DIV_RST;
        trimActQ <= `RCD_TRIM_RST;
        cntQ     <= {(`RCD_DIV_W+1){1'b0}};
        accQ     <= `RCD_TRIM_RST;
        extraQ   <= 1'b0;
        outQ     <= 1'b0;
    end else begin
        if (applyNew) begin
            divActQ  <= divQ;
            trimActQ <= trimQ;
        end
        if (!running) begin
            cntQ <= {(`RCD_DIV_W+1){1'b0}};
            if (!activeQ) begin
                outQ   <= 1'b0;
                accQ   <= `RCD_TRIM_RST;
                extraQ <= 1'b0;
            end
        end else if (bypass) begin
            // Undivided: follow the source level each cycle, toggle on system clock
            outQ <= (selQ == `RCD_SEL_SYSCLK) ? !outQ : srcHigh;
            cntQ <= {(`RCD_DIV_W+1){1'b0}};
        end else if (srcTick) begin
            if (halfDone) begin
                outQ   <= !outQ;
                cntQ   <= {(`RCD_DIV_W+1){1'b0}};
                accQ   <= accSum[`RCD_TRIM_W-1:0];
                extraQ <= accSum[`RCD_TRIM_W];
            end else begin
                cntQ <= cntNext;
            end
        end
    end
end

// ------------------------------------------------------------
// Control registers, switch and active flags
// ------------------------------------------------------------
always @(posedge core_clk) begin
    if (!rst_b) begin
        enableQ   <= 1'b0;
        selQ      <= `RCD_SEL_RST;
        sleepRunQ <= 1'b0;
        pinOeQ    <= 1'b0;
        switchQ   <= 1'b0;
        activeQ   <= 1'b0;
        divQ      <= `RCD_DIV_RST;
        trimQ     <= `RCD_TRIM_RST;
    end else begin
        if (wrLo) begin
            enableQ   <= loNew[`RCD_EN_BIT];
            pinOeQ    <= loNew[`RCD_OE_BIT];
            sleepRunQ <= loNew[`RCD_SLP_BIT];
            selQ      <= loNew[`RCD_SEL_HI:`RCD_SEL_LO];
        end
        if (wrHi)
            divQ <= hiNew[`RCD_DIV_HI:`RCD_DIV_LO];
        if (wrTrim)
            trimQ <= trimNew[`RCD_TRIM_HI:`RCD_TRIM_LO];
        // Software set wins over the hardware clear
        if (swSet)
            switchQ <= 1'b1;
        else if (applyNew)
            switchQ <= 1'b0;
        // Stop only at output low so the last pulse is whole
        if (enableQ)
            activeQ <= 1'b1;
        else if (!outQ)
            activeQ <= 1'b0;
    end
end

// ------------------------------------------------------------
// Outputs towards the remappable pin
// ------------------------------------------------------------
always @(posedge core_clk) begin
    if (!rst_b) begin
        refclkOutputFunction <= 1'b0;
        refclkPinOut         <= 1'b0;
    end else begin
        refclkOutputFunction <= outQ && activeQ;
        refclkPinOut         <= outQ && activeQ && pinOeQ;
    end
end

// ------------------------------------------------------------
// AXI4-Lite write path
// ------------------------------------------------------------
always @(posedge core_clk) begin
    if (!rst_b) begin
        awHeldQ      <= 1'b0;
        awAddrQ      <= {`RCD_ADDR_W{1'b0}};
        wHeldQ       <= 1'b0;
        wDataQ       <= 32'h0000_0000;
        wStrbQ       <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `RCD_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            awHeldQ <= 1'b1;
            awAddrQ <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeldQ <= 1'b1;
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
        end
        if (writeGo) begin
            awHeldQ      <= 1'b0;
            wHeldQ       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awAddrQ) ? `RCD_RESP_OKAY : `RCD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// AXI4-Lite read path
// ------------------------------------------------------------
reg [15:0] readImage;

always @* begin
    case (s_axi_araddr)
        `RCD_ADDR_CTRL_LO: readImage = ctrlLoImage;
        `RCD_ADDR_CTRL_HI: readImage = ctrlHiImage;
        `RCD_ADDR_TRIM:    readImage = trimImage;
        default:           readImage = 16'h0000;
    endcase
end

always @(posedge core_clk) begin
    if (!rst_b) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h0000_0000;
        s_axi_rresp  <= `RCD_RESP_OKAY;
    end else if (readGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, readImage};
        s_axi_rresp  <= mapped(s_axi_araddr) ? `RCD_RESP_OKAY : `RCD_RESP_SLVERR;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

/* File: design/rcd_regs.vh */
// Register map, field positions and reset values of the reference clock divider
`ifndef RCD_REGS_VH
`define RCD_REGS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define RCD_ADDR_W        4
`define RCD_ADDR_CTRL_LO  4'h0
`define RCD_ADDR_CTRL_HI  4'h4
`define RCD_ADDR_TRIM     4'h8

// ------------------------------------------------------------
// Low control register fields
// ------------------------------------------------------------
`define RCD_SEL_HI        3
`define RCD_SEL_LO        0
`define RCD_ACT_BIT       8
`define RCD_SW_BIT        9
`define RCD_SLP_BIT       11
`define RCD_OE_BIT        12
`define RCD_EN_BIT        15

// ------------------------------------------------------------
// High control and trim register fields
// ------------------------------------------------------------
`define RCD_DIV_HI        14
`define RCD_DIV_LO        0
`define RCD_TRIM_HI       15
`define RCD_TRIM_LO       7

// ------------------------------------------------------------
// Widths, reset values and bus answers
// ------------------------------------------------------------
`define RCD_SEL_W         4
`define RCD_DIV_W         15
`define RCD_TRIM_W        9
`define RCD_SRC_N         15
`define RCD_SEL_SYSCLK    4'h0
`define RCD_SEL_RST       4'h0
`define RCD_DIV_RST       15'h0000
`define RCD_TRIM_RST      9'h000
`define RCD_RESP_OKAY     2'b00
`define RCD_RESP_SLVERR   2'b10

`endif

/* File: bench/rcd_ref_clock_divider_asserts.sv */
// Port checks for the reference clock divider
`timescale 1ns/1ps
`include "rcd_regs.vh"
module rcd_ref_clock_divider_asserts (
    // Clock and reset
    input wire        core_clk,
    input wire        rst_b,
    // Register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Reference clock
    input wire        refclkOutputFunction,
    input wire        refclkPinOut
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data changed");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == `RCD_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read not zero");
    a_pin_gated: assert property (refclkPinOut |-> refclkOutputFunction)
        else $error("pin high without clock");
endmodule
bind rcd_ref_clock_divider rcd_ref_clock_divider_asserts u_asserts (.core_clk, .rst_b,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .refclkOutputFunction, .refclkPinOut);

/* File: bench/rcd_refclk_sink.sv */
// External consumer that times the reference clock on the mapped pin
`timescale 1ns/1ps
module rcd_refclk_sink (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // Mapped pin and measurements
    input  wire        refclkIn,
    output reg  [15:0] riseCount,
    output reg  [15:0] span
);
    reg [15:0] cyc;
    reg [15:0] t1;
    reg [15:0] t2;
    reg        prev;
    // Span covers two whole periods so a fractional step averages out
    always @(posedge core_clk) begin
        if (!rst_b) begin
            {riseCount, span, cyc, t1, t2, prev} <= {81{1'b0}};
        end else begin
            cyc  <= cyc + 16'h1;
            prev <= refclkIn;
            if (refclkIn && !prev) begin
                riseCount <= riseCount + 16'h1;
                t2        <= t1;
                t1        <= cyc;
                span      <= cyc - t2;
            end
        end
    end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the reference clock divider
`timescale 1ns/1ps
`include "rcd_regs.vh"
module tb;
    reg         core_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    reg  [31:0] s_axi_wdata = 32'h0, d, e;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleepMode = 1'b0;
    reg  [14:0] srcClkIn = 15'h0, dv;
    reg  [15:0] srcSleepEnabled = 16'h0;
    reg  [7:0]  lfsr = 8'h57;
    reg  [1:0]  r;
    reg  [3:0]  curSel = 4'h0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        refclkOutputFunction, refclkPinOut;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] riseCount, span, fRise, fSpan;
    integer     fails = 0, check_count = 0, k, q, cyc = 0;

    always #5 core_clk = ~core_clk;
    // Source q toggles every q+2 cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        for (q = 0; q < 15; q = q + 1) srcClkIn[q] <= ((cyc / (q + 2)) % 2) == 1;
    end

    rcd_ref_clock_divider u_dut (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .srcClkIn, .sleepMode, .srcSleepEnabled, .refclkOutputFunction, .refclkPinOut);
    rcd_refclk_sink u_sink (.core_clk, .rst_b, .refclkIn(refclkPinOut), .riseCount, .span);
    rcd_refclk_sink u_fsink (.core_clk, .rst_b, .refclkIn(refclkOutputFunction),
        .riseCount(fRise), .span(fSpan));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [7:0] nxt(input [7:0] x);
        nxt = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task final_report;
        begin
            $display("checks %0d mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input [8*6:1] what);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task tmo;
        begin
            chk(0, 1, "wait");
            final_report;
        end
    endtask
    task wr(input [3:0] a, input [31:0] v, output [1:0] resp);
        integer j;
        begin
            @(posedge core_clk);
            {s_axi_awaddr, s_axi_wdata} <= {a, v};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            for (j = 0; j < 40; j = j + 1) begin
                @(posedge core_clk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) begin
                    resp = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                    j = 99;
                end
            end
            if (j < 99) tmo;
        end
    endtask
    task rd(input [3:0] a, output [31:0] v, output [1:0] resp);
        integer j;
        begin
            @(posedge core_clk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            for (j = 0; j < 40; j = j + 1) begin
                @(posedge core_clk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) begin
                    {v, resp} = {s_axi_rdata, s_axi_rresp};
                    s_axi_rready <= 1'b0;
                    j = 99;
                end
            end
            if (j < 99) tmo;
        end
    endtask
    task waitbit(input integer b, input v);
        integer m;
        begin
            for (m = 0; m < 30; m = m + 1) begin
                rd(`RCD_ADDR_CTRL_LO, e, r);
                if (e[b] === v) m = 99;
            end
            if (m < 99) tmo;
        end
    endtask
    task cfg(input [3:0] sel, input [14:0] dvi, input [8:0] tr);
        begin
            // Disable with the source unchanged; settings move only once inactive
            wr(`RCD_ADDR_CTRL_LO, {28'h0, curSel}, r);
            waitbit(`RCD_ACT_BIT, 0);
            waitbit(`RCD_SW_BIT, 0);
            wr(`RCD_ADDR_CTRL_HI, {17'h0, dvi}, r);
            wr(`RCD_ADDR_TRIM, {16'h0, tr, 7'h0}, r);
            wr(`RCD_ADDR_CTRL_LO, 32'h200, r);
            waitbit(`RCD_SW_BIT, 0);
            wr(`RCD_ADDR_CTRL_LO, 32'h9000 | sel, r);
            curSel = sel;
            waitbit(`RCD_ACT_BIT, 1);
        end
    endtask
    task meas(input [15:0] ex);
        integer m;
        reg [15:0] n;
        begin
            n = riseCount;
            for (m = 0; m < 600; m = m + 1) begin
                @(posedge core_clk);
                if (riseCount - n >= 16'h3) m = 999;
            end
            if (m < 999) tmo;
            chk(span, ex, "span");
            chk(fSpan, ex, "fspan");
        end
    endtask
    task quiet(input run);
        reg [15:0] n;
        reg [15:0] fn;
        begin
            repeat (4) @(posedge core_clk);
            n = riseCount;
            fn = fRise;
            repeat (16) @(posedge core_clk);
            chk(riseCount, n, "rises");
            chk(fRise != fn, run, "frun");
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        for (k = 0; k < 3; k = k + 1) begin
            rd({k[1:0], 2'b00}, d, r);
            chk(d, 0, "reset");
        end
        rd(4'hc, d, r);
        chk(d, 32'h0, "unmap");
        chk(r, `RCD_RESP_SLVERR, "uresp");
        wr(4'hc, 32'hffff, r);
        chk(r, `RCD_RESP_SLVERR, "wresp");
        for (k = 0; k < 4; k = k + 1) begin
            lfsr = nxt(lfsr);
            d = {4{lfsr}};
            wr(`RCD_ADDR_CTRL_HI, d, r);
            rd(`RCD_ADDR_CTRL_HI, e, r);
            chk(e, d & 32'h7fff, "div");
            wr(`RCD_ADDR_TRIM, d, r);
            rd(`RCD_ADDR_TRIM, e, r);
            chk(e, d & 32'hff80, "trim");
        end
        $display("test registers done");
        // The sink sits on the high-drive pin: every setting stays at or below 32 MHz
        cfg(4'h1, 15'h0, 9'h0);
        meas(16'h8);
        for (k = 0; k < 4; k = k + 1) begin
            lfsr = nxt(lfsr);
            dv = 15'h2 + lfsr[3:0];
            cfg(4'h0, dv, 9'h0);
            meas({dv[13:0], 2'b00});
        end
        cfg(4'h0, 15'h2, 9'h100);
        meas(16'ha);
        $display("test divider done");
        for (k = 1; k < 16; k = k + 1) begin
            cfg(k[3:0], 15'h1, 9'h0);
            meas(16'h8 * (k[15:0] + 16'h1));
        end
        $display("test sources done");
        cfg(4'h0, 15'h2, 9'h0);
        wr(`RCD_ADDR_CTRL_LO, 32'h8000, r);
        quiet(1'b1);
        sleepMode <= 1'b1;
        wr(`RCD_ADDR_CTRL_LO, 32'h9000, r);
        quiet(1'b0);
        srcSleepEnabled <= 16'h1;
        wr(`RCD_ADDR_CTRL_LO, 32'h9800, r);
        meas(16'h8);
        sleepMode <= 1'b0;
        wr(`RCD_ADDR_CTRL_LO, 32'h0, r);
        waitbit(`RCD_ACT_BIT, 0);
        $display("test gating done");
        final_report;
    end
endmodule
